// *** hdl/sgp_pkg.sv ***
package sgp_pkg;
    typedef struct packed {
        logic rsvd;
        logic deb_en;
        logic edge_pol;
        logic evt_type;
        logic lock;
        logic pull_up;
        logic push_pull;
        logic out_en;
    } sgp_cfg_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } sgp_req_t;

    localparam logic [2:0] A_DO0 = 3'h0;
    localparam logic [2:0] A_DI0 = 3'h1;
    localparam logic [2:0] A_DO1 = 3'h2;
    localparam logic [2:0] A_DI1 = 3'h3;
    localparam logic [2:0] A_SEL = 3'h4;
    localparam logic [2:0] A_CFG = 3'h5;

    localparam int         SEL_PORT_BIT = 4;
    localparam logic [7:0] SEL_MASK     = 8'h17;
    localparam logic [7:0] SEL_RST      = 8'h00;
    localparam logic [7:0] CFG_RST_P0   = 8'h44;
    localparam logic [7:0] CFG_RST_OUT  = 8'h05;
    localparam logic [7:0] DO_RST       = 8'h00;
    localparam logic [7:0] P1_MASK      = 8'h0F;
    localparam int         N_IO         = 6;

    localparam int DEB_MS  = 15;
    localparam int CLK_HZ  = 40_000_000;
    localparam int DEB_CYC = DEB_MS * (CLK_HZ / 1000);
endpackage

// *** hdl/sgp_standby_pins.sv ***
`timescale 1ns/1ps
module sgp_standby_pins #(
    parameter int DEBOUNCE_CYCLES = sgp_pkg::DEB_CYC
) (
    input  wire logic             core_clk_i,
    input  wire logic             resetn_i,
    input  wire sgp_pkg::sgp_req_t reg_req_i,
    output logic [7:0]            reg_rdata_o,
    input  wire logic             wake_up_controller_active_i,
    input  wire logic [5:0]       standby_bidir_pins_i,
    output logic [5:0]            standby_bidir_pins_o,
    output logic [5:0]            standby_bidir_pins_oe_n_o,
    output logic [5:0]            standby_bidir_pins_pullup_o,
    input  wire logic [1:0]       standby_event_inputs_i,
    input  wire logic [1:0]       standby_output_pins_i,
    output logic [1:0]            standby_output_pins_o,
    output logic [1:0]            standby_output_pins_oe_n_o,
    output logic [1:0]            standby_output_pins_pullup_o,
    input  wire logic [1:0]       standby_plain_inputs_i,
    output logic [7:0]            event_pending_o
);
    localparam int CW = $clog2(DEBOUNCE_CYCLES + 1);

    function automatic sgp_pkg::sgp_cfg_t cfg_write(sgp_pkg::sgp_cfg_t old, logic [7:0] wd,
                                                   logic has_io, logic has_evt);
        sgp_pkg::sgp_cfg_t n;
        n = old;
        if (has_io && !old.lock) begin
            n.out_en    = wd[0];
            n.push_pull = wd[1];
            n.pull_up   = wd[2];
            n.lock      = wd[3];
        end
        if (has_evt) begin
            n.evt_type = wd[4];
            n.edge_pol = wd[5];
            n.deb_en   = wd[6];
        end
        return n;
    endfunction

    sgp_pkg::sgp_cfg_t cfg [0:9];
    logic [7:0]        pin_index_select;
    logic [7:0]        port_output_value0;
    logic [3:0]        port_output_value1;
    logic [11:0]       sync1;
    logic [11:0]       sync2;
    logic [7:0]        filt;
    logic [7:0]        filt_prev;
    logic [CW-1:0]     cnt [0:7];

    // Runtime access is fenced by the controller activation; setup stays reachable
    wire       rt_ok     = wake_up_controller_active_i;
    wire       wr_do0    = reg_req_i.wr && reg_req_i.addr == sgp_pkg::A_DO0 && rt_ok;
    wire       wr_do1    = reg_req_i.wr && reg_req_i.addr == sgp_pkg::A_DO1 && rt_ok;
    wire       wr_sel    = reg_req_i.wr && reg_req_i.addr == sgp_pkg::A_SEL;
    wire       wr_cfg    = reg_req_i.wr && reg_req_i.addr == sgp_pkg::A_CFG;
    wire       sel_port1 = pin_index_select[sgp_pkg::SEL_PORT_BIT];
    wire [2:0] sel_pin   = pin_index_select[2:0];
    // Port 1 plain inputs need no setup, so only its two output pins are selectable
    wire       sel_valid = !sel_port1 || sel_pin < 3'h2;
    wire [3:0] sel_idx   = sel_port1 ? {3'h4, sel_pin[0]} : {1'b0, sel_pin};
    wire [7:0] cfg_rd    = sel_valid ? cfg[sel_idx] : 8'h00;

    wire [7:0] lock0     = {2'b00, cfg[5].lock, cfg[4].lock, cfg[3].lock,
                            cfg[2].lock, cfg[1].lock, cfg[0].lock};
    wire [1:0] lock1     = {cfg[9].lock, cfg[8].lock};
    wire [7:0] next_do0  = (port_output_value0 & lock0) | (reg_req_i.wdata & ~lock0);
    wire [3:0] next_do1  = {reg_req_i.wdata[3:2],
                            (port_output_value1[1:0] & lock1) | (reg_req_i.wdata[1:0] & ~lock1)};

    // Pin levels seen by software: bidir 0-5, events 6-7 | outputs 0-1, plain 2-3
    wire [7:0] level0    = sync2[7:0];
    wire [7:0] level1    = {4'h0, sync2[11:8]};

    wire [7:0] rd_val =
        (reg_req_i.addr == sgp_pkg::A_DO0 && rt_ok) ? port_output_value0 :
        (reg_req_i.addr == sgp_pkg::A_DI0 && rt_ok) ? level0 :
        (reg_req_i.addr == sgp_pkg::A_DO1 && rt_ok) ? {4'h0, port_output_value1} :
        (reg_req_i.addr == sgp_pkg::A_DI1 && rt_ok) ? level1 :
        (reg_req_i.addr == sgp_pkg::A_SEL)          ? pin_index_select :
        (reg_req_i.addr == sgp_pkg::A_CFG)          ? cfg_rd : 8'h00;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_index_select <= sgp_pkg::SEL_RST;
        end else if (wr_sel) begin
            pin_index_select <= reg_req_i.wdata & sgp_pkg::SEL_MASK;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            port_output_value0 <= sgp_pkg::DO_RST;
            port_output_value1 <= sgp_pkg::DO_RST[3:0];
        end else begin
            if (wr_do0) begin
                port_output_value0 <= next_do0;
            end
            if (wr_do1) begin
                port_output_value1 <= next_do1;
            end
        end
    end

    // Data-in has no write path at all
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_req_i.rd) begin
            reg_rdata_o <= rd_val;
        end
    end

    // Pins arrive from outside the clock domain
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync1 <= 12'h000;
            sync2 <= 12'h000;
        end else begin
            sync1 <= {standby_plain_inputs_i, standby_output_pins_i,
                      standby_event_inputs_i, standby_bidir_pins_i};
            sync2 <= sync1;
        end
    end

    for (genvar i = 0; i < 10; i++) begin : g_cfg
        localparam logic HAS_IO  = (i < sgp_pkg::N_IO) || (i >= 8);
        localparam logic HAS_EVT = (i < 8);
        localparam logic [7:0] RST = (i < 8) ? sgp_pkg::CFG_RST_P0 : sgp_pkg::CFG_RST_OUT;
        wire we = wr_cfg && sel_valid && sel_idx == 4'(i);
        always_ff @(posedge core_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                cfg[i] <= RST;
            end else if (we) begin
                cfg[i] <= cfg_write(cfg[i], reg_req_i.wdata, HAS_IO, HAS_EVT);
            end
        end
    end

    for (genvar i = 0; i < 8; i++) begin : g_evt
        wire stable_hit = cnt[i] == CW'(DEBOUNCE_CYCLES - 1);
        always_ff @(posedge core_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                cnt[i]             <= '0;
                filt[i]            <= 1'b0;
                filt_prev[i]       <= 1'b0;
                event_pending_o[i] <= 1'b0;
            end else begin
                filt_prev[i] <= filt[i];
                if (!cfg[i].deb_en || sync2[i] == filt[i]) begin
                    cnt[i] <= '0;
                    filt[i] <= sync2[i];
                end else if (stable_hit) begin
                    cnt[i] <= '0;
                    filt[i] <= sync2[i];
                end else begin
                    cnt[i] <= cnt[i] + CW'(1);
                end
                // Level trigger is not implemented, so type 1 never flags
                event_pending_o[i] <= !cfg[i].evt_type && (cfg[i].edge_pol ? (filt[i] && !filt_prev[i])
                                                         : (!filt[i] && filt_prev[i]));
            end
        end
    end

    // Open drain only ever pulls low, releasing the pin for a one
    for (genvar i = 0; i < 6; i++) begin : g_bidir
        assign standby_bidir_pins_o[i]      = port_output_value0[i] && cfg[i].push_pull;
        assign standby_bidir_pins_oe_n_o[i] = !(cfg[i].out_en && (cfg[i].push_pull || !port_output_value0[i]));
        assign standby_bidir_pins_pullup_o[i] = cfg[i].pull_up;
    end
    for (genvar i = 0; i < 2; i++) begin : g_out
        assign standby_output_pins_o[i]      = port_output_value1[i] && cfg[8+i].push_pull;
        assign standby_output_pins_oe_n_o[i] = !(cfg[8+i].out_en && (cfg[8+i].push_pull || !port_output_value1[i]));
        assign standby_output_pins_pullup_o[i] = cfg[8+i].pull_up;
    end

    sequence s_locked_do0_write;
        cfg[0].lock && wr_do0;
    endsequence

    sequence s_inactive_read;
        reg_req_i.rd && !rt_ok && reg_req_i.addr <= sgp_pkg::A_DI1;
    endsequence

    a_lock_sticky: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        cfg[0].lock |=> cfg[0].lock)
        else $error("lock bit cleared without reset");

    a_locked_do_kept: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        s_locked_do0_write |=> port_output_value0[0] == $past(port_output_value0[0]))
        else $error("locked data-out bit changed");

    a_locked_cfg_kept: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        cfg[0].lock |=> cfg[0][3:0] == $past(cfg[0][3:0]))
        else $error("locked setup bits changed");

    a_inactive_read_zero: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        s_inactive_read |=> reg_rdata_o == 8'h00)
        else $error("runtime read while inactive returned data");

    a_do_readback: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        reg_req_i.rd && rt_ok && reg_req_i.addr == sgp_pkg::A_DO0 |=> reg_rdata_o == $past(port_output_value0))
        else $error("data-out read mismatch");

    a_p1_upper_zero: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        reg_req_i.rd && (reg_req_i.addr == sgp_pkg::A_DI1 || reg_req_i.addr == sgp_pkg::A_DO1)
        |=> reg_rdata_o[7:4] == 4'h0)
        else $error("port 1 upper bits not zero");

    a_pin_drive: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        cfg[0].out_en && cfg[0].push_pull |-> !standby_bidir_pins_oe_n_o[0]
                                           && standby_bidir_pins_o[0] == port_output_value0[0])
        else $error("enabled pin not driving data-out");

    a_od_release: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        !cfg[0].push_pull && port_output_value0[0] |-> standby_bidir_pins_oe_n_o[0])
        else $error("open-drain pin driven high");

    a_fall_event: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        $fell(filt[0]) && !cfg[0].edge_pol && !cfg[0].evt_type |=> event_pending_o[0])
        else $error("falling edge not flagged");

    a_debounce_wait: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        $changed(filt[0]) && $past(cfg[0].deb_en) |-> $past(cnt[0]) == CW'(DEBOUNCE_CYCLES - 1))
        else $error("debounced input passed early");

    // Select/setup registers, both ports and the event pins get further checks, the bench reaches some less often
    sequence s_locked_do1_write;
        cfg[8].lock && wr_do1;
    endsequence

    sequence s_inactive_write;
        reg_req_i.wr && !rt_ok && reg_req_i.addr <= sgp_pkg::A_DI1;
    endsequence

    sequence s_debounce_waiting;
        cfg[6].deb_en && sync2[6] != filt[6] && cnt[6] != CW'(DEBOUNCE_CYCLES - 1);
    endsequence

    a_sel_masked: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        wr_sel |=> pin_index_select == ($past(reg_req_i.wdata) & sgp_pkg::SEL_MASK))
        else $error("select register kept reserved bits");

    a_sel_read: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        reg_req_i.rd && reg_req_i.addr == sgp_pkg::A_SEL |=> reg_rdata_o == $past(pin_index_select))
        else $error("select register read mismatch");

    a_cfg_read: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        reg_req_i.rd && reg_req_i.addr == sgp_pkg::A_CFG |=> reg_rdata_o == $past(cfg_rd))
        else $error("setup window read mismatch");

    a_di0_read: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        reg_req_i.rd && rt_ok && reg_req_i.addr == sgp_pkg::A_DI0
        |=> reg_rdata_o == $past(sync2[7:0]))
        else $error("port 0 level read mismatch");

    a_di1_read: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        reg_req_i.rd && rt_ok && reg_req_i.addr == sgp_pkg::A_DI1
        |=> reg_rdata_o == {4'h0, $past(sync2[11:8])})
        else $error("port 1 level read mismatch");

    a_di_no_write: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        reg_req_i.wr && reg_req_i.addr == sgp_pkg::A_DI0 |=> $stable(port_output_value0))
        else $error("data-in write changed data-out");

    a_inactive_kept: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        s_inactive_write |=> $stable(port_output_value0) && $stable(port_output_value1))
        else $error("runtime write landed while inactive");

    a_do1_locked: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        s_locked_do1_write |=> port_output_value1[0] == $past(port_output_value1[0]))
        else $error("locked port 1 data-out bit changed");

    a_do1_inputs: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        wr_do1 |=> port_output_value1[3:2] == $past(reg_req_i.wdata[3:2]))
        else $error("port 1 data-out bits 2-3 not stored");

    a_do0_write: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        wr_do0 && lock0 == 8'h00 |=> port_output_value0 == $past(reg_req_i.wdata))
        else $error("unlocked data-out write lost");

    a_rdata_hold: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        !reg_req_i.rd |=> $stable(reg_rdata_o))
        else $error("read data changed without a read");

    a_out_drive: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        cfg[8].out_en && cfg[8].push_pull
        |-> !standby_output_pins_oe_n_o[0] && standby_output_pins_o[0] == port_output_value1[0])
        else $error("enabled output pin not driving data-out");

    a_od_pull_low: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        cfg[0].out_en && !cfg[0].push_pull && !port_output_value0[0]
        |-> !standby_bidir_pins_oe_n_o[0] && !standby_bidir_pins_o[0])
        else $error("open-drain pin not pulling low");

    a_out_disabled: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        !cfg[0].out_en |-> standby_bidir_pins_oe_n_o[0])
        else $error("disabled pin still driven");

    a_pullup_follow: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        standby_bidir_pins_pullup_o[0] == cfg[0].pull_up && standby_output_pins_pullup_o[0] == cfg[8].pull_up)
        else $error("pull-up does not follow setup");

    a_rise_event: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        $rose(filt[0]) && cfg[0].edge_pol && !cfg[0].evt_type |=> event_pending_o[0])
        else $error("rising edge not flagged");

    a_type_silent: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        cfg[0].evt_type |=> !event_pending_o[0])
        else $error("unsupported event type flagged");

    a_pend_pulse: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        event_pending_o[6] |=> !event_pending_o[6])
        else $error("event pending longer than one cycle");

    a_pend_edge: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        event_pending_o[6] |-> $past(filt[6]) != $past(filt_prev[6]))
        else $error("event pending without an edge");

    a_p1_lock_sticky: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        cfg[8].lock |=> cfg[8].lock)
        else $error("port 1 lock cleared without reset");

    a_evt_pin_static: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        cfg[6][3:0] == 4'h4 && cfg[7][3:0] == 4'h4)
        else $error("input-only pin gained output setup");

    a_p1_no_event: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        cfg[8][7:4] == 4'h0 && cfg[9][7:4] == 4'h0)
        else $error("port 1 setup gained event bits");

    a_sync_path: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        sync2 == $past(sync1))
        else $error("pin synchroniser skipped a stage");

    a_debounce_hold: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        s_debounce_waiting |=> $stable(filt[6]))
        else $error("debounced input moved before the wait ended");

    a_nodeb_follow: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        !cfg[6].deb_en
        |=> filt[6] == $past(sync2[6]))
        else $error("undebounced input did not follow pin");
endmodule

// *** tb/sgp_pin_world.sv ***
`timescale 1ns/1ps
// Far-side pin wires: device drive wins, then an external driver, then the
// pull-up; a floating pin toggles so a stale value never looks valid.
module sgp_pin_world (
    input  wire logic       core_clk_i,
    input  wire logic [7:0] drv_i,
    input  wire logic [7:0] oe_n_i,
    input  wire logic [7:0] pullup_i,
    input  wire logic [7:0] ext_en_i,
    input  wire logic [7:0] ext_val_i,
    output logic [7:0]      level_o
);
    logic [7:0] flip = 8'h55;
    always @(posedge core_clk_i) flip <= ~flip;
    assign level_o = (~oe_n_i & drv_i) | (oe_n_i & ext_en_i & ext_val_i)
                   | (oe_n_i & ~ext_en_i & (pullup_i | flip));
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
    logic core_clk_i = 0;
    logic resetn_i = 0;
    logic act = 1;
    sgp_pkg::sgp_req_t req = '0;
    logic [7:0] rdata, pend, lvl, ext_en = 8'h00, ext_val = 8'h00;
    logic [5:0] b_o, b_oe_n, b_pu;
    logic [1:0] o_o, o_oe_n, o_pu, evt = 2'h3, plain = 2'h1;
    int n_fail = 0;
    int checked = 0;
    always #12.5 core_clk_i = ~core_clk_i;
    sgp_standby_pins #(.DEBOUNCE_CYCLES(8)) i_dut (
        .core_clk_i(core_clk_i), .resetn_i(resetn_i), .reg_req_i(req), .reg_rdata_o(rdata),
        .wake_up_controller_active_i(act), .standby_bidir_pins_i(lvl[5:0]),
        .standby_bidir_pins_o(b_o), .standby_bidir_pins_oe_n_o(b_oe_n), .standby_bidir_pins_pullup_o(b_pu),
        .standby_event_inputs_i(evt), .standby_output_pins_i(lvl[7:6]), .standby_output_pins_o(o_o),
        .standby_output_pins_oe_n_o(o_oe_n), .standby_output_pins_pullup_o(o_pu),
        .standby_plain_inputs_i(plain), .event_pending_o(pend));
    sgp_pin_world i_world (
        .core_clk_i(core_clk_i), .drv_i({o_o, b_o}), .oe_n_i({o_oe_n, b_oe_n}), .pullup_i({o_pu, b_pu}),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(lvl));
    task automatic print_verdict();
        if (n_fail == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic acc(logic w, logic [2:0] a, logic [7:0] d);
        @(posedge core_clk_i) #2;
        req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge core_clk_i) #2;
        req = '0;
    endtask
    task automatic rd(string n, logic [2:0] a, logic [7:0] exp);
        acc(0, a, 8'h00);
        chk(n, rdata, exp);
    endtask
    task automatic do_reset();
        resetn_i = 0;
        repeat (12) @(posedge core_clk_i);
        #2 resetn_i = 1;
    endtask
    // Settle the pin on the opposite level first, then time the pulse
    task automatic evt_try(logic [7:0] cfg, logic fin, logic exp, int minc);
        int c;
        logic seen;
        c = 0;
        seen = 0;
        acc(1, sgp_pkg::A_CFG, cfg);
        evt[0] = ~fin;
        repeat (20) @(posedge core_clk_i);
        #2 evt[0] = fin;
        for (int i = 0; i < 30; i++) begin
            @(posedge core_clk_i) #1;
            if (pend[6] === 1'b1 && !seen) begin
                seen = 1;
                c = i;
            end
        end
        chk("pend6", {7'h0, seen}, {7'h0, exp});
        if (exp) chk("deb", {7'h0, c >= minc}, 8'h01);
    endtask
    initial begin
        #100000;
        n_fail++;
        print_verdict();
    end
    initial begin
        do_reset();
        rd("cfg00", sgp_pkg::A_CFG, 8'h44);
        rd("do0", sgp_pkg::A_DO0, 8'h00);
        chk("b_oe_n", {2'h0, b_oe_n}, 8'h3F);
        chk("o_oe_n", {6'h0, o_oe_n}, 8'h00);
        chk("b_pu", {2'h0, b_pu}, 8'h3F);
        acc(1, sgp_pkg::A_SEL, 8'h10);
        rd("cfg10", sgp_pkg::A_CFG, 8'h05);
        acc(1, sgp_pkg::A_SEL, 8'h00);
        acc(1, sgp_pkg::A_DO0, 8'hA5);
        acc(1, sgp_pkg::A_DI0, 8'h00);
        rd("do0", sgp_pkg::A_DO0, 8'hA5);
        acc(1, sgp_pkg::A_CFG, 8'h03);
        chk("b0", {b_oe_n[0], b_o[0]}, 8'h01);
        ext_en = 8'h3E;
        ext_val = 8'h2C;
        repeat (4) @(posedge core_clk_i);
        rd("di0", sgp_pkg::A_DI0, 8'hED);
        rd("di1", sgp_pkg::A_DI1, 8'h04);
        acc(1, sgp_pkg::A_DO1, 8'hFF);
        rd("do1", sgp_pkg::A_DO1, 8'h0F);
        chk("o_oe_n", {6'h0, o_oe_n}, 8'h03);
        repeat (4) @(posedge core_clk_i);
        rd("di1", sgp_pkg::A_DI1, 8'h07);
        acc(1, sgp_pkg::A_CFG, 8'h0B);
        rd("cfg lock", sgp_pkg::A_CFG, 8'h0B);
        acc(1, sgp_pkg::A_DO0, 8'h00);
        rd("do0 lock", sgp_pkg::A_DO0, 8'h01);
        acc(1, sgp_pkg::A_CFG, 8'h00);
        rd("cfg lock", sgp_pkg::A_CFG, 8'h0B);
        @(posedge core_clk_i) #2 act = 0;
        rd("do0 off", sgp_pkg::A_DO0, 8'h00);
        acc(1, sgp_pkg::A_DO0, 8'hFE);
        chk("b0 off", {b_oe_n[0], b_o[0]}, 8'h01);
        @(posedge core_clk_i) #2 act = 1;
        rd("do0 on", sgp_pkg::A_DO0, 8'h01);
        acc(1, sgp_pkg::A_SEL, 8'h06);
        evt_try(8'h00, 0, 1, 0);
        evt_try(8'h20, 1, 1, 0);
        evt_try(8'h30, 1, 0, 0);
        evt_try(8'h00, 1, 0, 0);
        evt_try(8'h40, 0, 1, 8);
        do_reset();
        rd("cfg rst", sgp_pkg::A_CFG, 8'h44);
        print_verdict();
    end
endmodule
